// ===== hw/pti_pkg.sv
// constants, field layouts and types shared by the periodic tick interrupt block
package pti_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ENA_OFS  = 8'h04;
  localparam logic [7:0] FLAG_OFS = 8'h08;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned LOW_VOLTAGE_DETECT_OUTPUT_BIT      = 5;
  localparam int unsigned ENA_W         = 4;
  localparam int unsigned FLAG_W        = 3;
  localparam logic [4:0]  CTRL_RST      = 5'h00;
  localparam logic [3:0]  ENA_RST       = 4'h0;
  localparam logic [2:0]  FLAG_RST      = 3'h0;

  // ---------------------------------------------------------------
  // vector, divider and clock source constants
  // ---------------------------------------------------------------
  localparam logic [11:0] MF0_VECTOR    = 12'h024;
  localparam logic [3:0]  RTC_EXP_BASE  = 4'h8;
  localparam logic [3:0]  TB_EXP_MIN    = 4'hC;
  localparam logic [3:0]  TB_EXP_MAX    = 4'hF;
  localparam logic [3:0]  TB_EXP_RST    = 4'hF;
  localparam logic [1:0]  SYS_DIV_LAST  = 2'h3;
  localparam logic [1:0]  SRC_CRYSTAL   = 2'h0;
  localparam logic [1:0]  SRC_INT_RC    = 2'h1;
  localparam logic [1:0]  SRC_SYS_DIV4  = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       osc_quick_start_off;
    logic       low_voltage_detect_enable;
    logic [2:0] rtc_period_select;
  } pti_ctrl_t;

  typedef struct packed {
    logic mf0_irq_enable;
    logic tick_irq_enable;
    logic rtc_irq_enable;
    logic global_irq_enable;
  } pti_ena_t;

  typedef struct packed {
    logic mf0_request_flag;
    logic tick_request_flag;
    logic rtc_request_flag;
  } pti_flag_t;

  typedef enum logic [1:0] {
    PTI_IDLE  = 2'b00,
    PTI_ENTER = 2'b01,
    PTI_ISR   = 2'b11
  } pti_svc_t;

  // low mask of e ones, used by both dividers
  function automatic logic [14:0] div_mask(input logic [3:0] e);
    logic [15:0] one_hot;
    one_hot = 16'h0001 << e;
    return one_hot[14:0] - 15'h0001;
  endfunction

endpackage

// ===== hw/pti_tick_div.sv
// free-running power-of-two divider on the slow clock tick
`timescale 1ns/10ps
module pti_tick_div (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic [3:0] exp_i,
  output logic            ovf_o
);

  logic [14:0] cnt_ff;
  logic        ovf_ff;
  logic [14:0] mask;

  // ------------------------------------------------------------
  // counter and overflow
  // ------------------------------------------------------------
  assign mask = pti_pkg::div_mask(exp_i);

  // counter never stops; a new ratio only moves the next wrap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 15'h0000;
    end else if (tick_i) begin
      cnt_ff <= cnt_ff + 15'h0001;
    end
  end

  // one pulse per completed period of 2^exp slow ticks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_ff <= 1'b0;
    end else begin
      ovf_ff <= tick_i && ((cnt_ff & mask) == mask);
    end
  end

  assign ovf_o = ovf_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_ovf_on_wrap;
    @(posedge clk_i) disable iff (rst_i)
    ovf_ff |-> $past(tick_i) && (($past(cnt_ff) & $past(mask)) == $past(mask));
  endproperty
  a_ovf_on_wrap: assert property (p_ovf_on_wrap) else $error("divider pulse without wrap");

endmodule

// ===== hw/pti_top.sv
// periodic tick interrupts: rtc and time base dividers feeding the mf0 interrupt
`timescale 1ns/10ps
module pti_top #(
  parameter logic [1:0] SLOW_SRC = pti_pkg::SRC_CRYSTAL,
  parameter logic [3:0] TB_EXP   = pti_pkg::TB_EXP_RST
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        XTAL_SLOW_I,
  input  wire logic        INTERNAL_RC_SLOW_OSC_SLOW_I,
  input  wire logic        LVD_SENSE_I,
  input  wire logic        STACK_FULL_I,
  input  wire logic        RETURN_AND_UNMASK_I,
  input  wire logic        RET_I,
  input  wire logic        SIO0_REQ_I,
  input  wire logic        EXT_PERIPH_REQ_I,
  output logic             CALL_O,
  output logic             PUSH_PC_O,
  output logic [11:0]      VECTOR_O,
  output logic             WAKE_O,
  output logic             LVD_ENABLE_O,
  output logic             OSC_QUICK_START_O,
  output logic             GLOBAL_IRQ_ENABLE_O
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (TB_EXP < pti_pkg::TB_EXP_MIN || TB_EXP > pti_pkg::TB_EXP_MAX) begin : g_bad_tb
    $error("time base exponent out of range");
  end
  if (SLOW_SRC > pti_pkg::SRC_SYS_DIV4) begin : g_bad_src
    $error("slow clock source code out of range");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  pti_pkg::pti_ctrl_t ctrl_ff;
  pti_pkg::pti_ena_t  ena_ff;
  pti_pkg::pti_ena_t  nxt_ena;
  pti_pkg::pti_flag_t flag_ff;
  pti_pkg::pti_flag_t nxt_flag;
  pti_pkg::pti_svc_t  svc_ff;
  pti_pkg::pti_svc_t  nxt_svc;
  logic [2:0]         sync1_ff;
  logic [2:0]         sync2_ff;
  logic [2:0]         prev_ff;
  logic [1:0]         sys_div_ff;
  logic               slow_tick;
  logic               rtc_ovf;
  logic               tb_ovf;
  logic [3:0]         rtc_exp;
  logic               mf0_set;
  logic               can_call;
  logic               wake_ff;
  logic [31:0]        prdata_ff;
  logic [31:0]        rd_data;
  logic               rd_hit;
  logic               setup;
  logic               wr_en;
  logic               wr_ctrl;
  logic               wr_ena;
  logic               wr_flag;
  logic               lvd_out;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // bit 0 crystal, bit 1 rc, bit 2 detector sense; both
  // oscillators are slow enough to be sampled as levels
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff  <= 3'h0;
    end else begin
      sync1_ff <= {LVD_SENSE_I, INTERNAL_RC_SLOW_OSC_SLOW_I, XTAL_SLOW_I};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // ------------------------------------------------------------
  // slow clock source
  // ------------------------------------------------------------
  // system clock over four needs no crossing
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sys_div_ff <= 2'h0;
    end else begin
      sys_div_ff <= sys_div_ff + 2'h1;
    end
  end

  // source is a build option, not a register field
  always_comb begin
    case (SLOW_SRC)
      pti_pkg::SRC_CRYSTAL:  slow_tick = sync2_ff[0] & ~prev_ff[0];
      pti_pkg::SRC_INT_RC:   slow_tick = sync2_ff[1] & ~prev_ff[1];
      pti_pkg::SRC_SYS_DIV4: slow_tick = (sys_div_ff == pti_pkg::SYS_DIV_LAST);
      default:               slow_tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // tick dividers
  // ------------------------------------------------------------
  // select n maps to exponent 8 + n
  assign rtc_exp = pti_pkg::RTC_EXP_BASE + {1'b0, ctrl_ff.rtc_period_select};

  pti_tick_div u_rtc_div (
    .clk_i  (REF_CLK_I),
    .rst_i  (RESET_I),
    .tick_i (slow_tick),
    .exp_i  (rtc_exp),
    .ovf_o  (rtc_ovf)
  );

  // time base ratio is fixed at build time
  pti_tick_div u_tb_div (
    .clk_i  (REF_CLK_I),
    .rst_i  (RESET_I),
    .tick_i (slow_tick),
    .exp_i  (TB_EXP),
    .ovf_o  (tb_ovf)
  );

  // ------------------------------------------------------------
  // apb slave decode
  // ------------------------------------------------------------
  // zero wait states: read data is latched in the setup cycle
  assign setup   = PSEL_I & ~PENABLE_I;
  assign wr_en   = PSEL_I & PENABLE_I & PWRITE_I & PSTRB_I[0];
  assign wr_ctrl = wr_en & (PADDR_I == pti_pkg::CTRL_OFS);
  assign wr_ena  = wr_en & (PADDR_I == pti_pkg::ENA_OFS);
  assign wr_flag = wr_en & (PADDR_I == pti_pkg::FLAG_OFS);

  // low voltage output reads zero while the detector is off
  assign lvd_out = ctrl_ff.low_voltage_detect_enable & sync2_ff[2];

  // read mux; reserved bits read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (PADDR_I)
      pti_pkg::CTRL_OFS: begin
        rd_data[pti_pkg::CTRL_W-1:0] = ctrl_ff;
        rd_data[pti_pkg::LOW_VOLTAGE_DETECT_OUTPUT_BIT]   = lvd_out;
      end
      pti_pkg::ENA_OFS: begin
        rd_data[pti_pkg::ENA_W-1:0] = ena_ff;
      end
      pti_pkg::FLAG_OFS: begin
        rd_data[pti_pkg::FLAG_W-1:0] = flag_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup && !PWRITE_I) begin
      prdata_ff <= rd_data;
    end
  end

  assign PRDATA_O  = prdata_ff;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~rd_hit;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_ff <= pti_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= PWDATA_I[pti_pkg::CTRL_W-1:0];
    end
  end

  assign OSC_QUICK_START_O = ~ctrl_ff.osc_quick_start_off;
  assign LVD_ENABLE_O      = ctrl_ff.low_voltage_detect_enable;

  // ------------------------------------------------------------
  // service sequencer
  // ------------------------------------------------------------
  // a call is offered only from idle, so one entry per request
  assign can_call = (svc_ff == pti_pkg::PTI_IDLE) & ena_ff.global_irq_enable
                  & ena_ff.mf0_irq_enable & flag_ff.mf0_request_flag
                  & ~STACK_FULL_I;

  always_comb begin
    case (svc_ff)
      pti_pkg::PTI_IDLE:  nxt_svc = can_call ? pti_pkg::PTI_ENTER : pti_pkg::PTI_IDLE;
      pti_pkg::PTI_ENTER: nxt_svc = pti_pkg::PTI_ISR;
      pti_pkg::PTI_ISR:   nxt_svc = (RETURN_AND_UNMASK_I | RET_I) ? pti_pkg::PTI_IDLE : pti_pkg::PTI_ISR;
      default:            nxt_svc = pti_pkg::PTI_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      svc_ff <= pti_pkg::PTI_IDLE;
    end else begin
      svc_ff <= nxt_svc;
    end
  end

  // entry only pushes the program counter, nothing else
  assign CALL_O    = (svc_ff == pti_pkg::PTI_ENTER);
  assign PUSH_PC_O = (svc_ff == pti_pkg::PTI_ENTER);
  assign VECTOR_O  = pti_pkg::MF0_VECTOR;

  // ------------------------------------------------------------
  // enable register
  // ------------------------------------------------------------
  // entry clears the global enable; return with unmask sets it
  always_comb begin
    nxt_ena = ena_ff;
    if (wr_ena) begin
      nxt_ena = PWDATA_I[pti_pkg::ENA_W-1:0];
    end
    if (can_call) begin
      nxt_ena.global_irq_enable = 1'b0;
    end
    if (RETURN_AND_UNMASK_I && svc_ff == pti_pkg::PTI_ISR) begin
      nxt_ena.global_irq_enable = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ena_ff <= pti_pkg::ENA_RST;
    end else begin
      ena_ff <= nxt_ena;
    end
  end

  assign GLOBAL_IRQ_ENABLE_O = ena_ff.global_irq_enable;

  // ------------------------------------------------------------
  // request flags
  // ------------------------------------------------------------
  // rtc and tick raise mf0 only through their own enable; sio0 and external requests set it directly
  assign mf0_set = (rtc_ovf & ena_ff.rtc_irq_enable)
                 | (tb_ovf & ena_ff.tick_irq_enable)
                 | SIO0_REQ_I | EXT_PERIPH_REQ_I;

  // hardware sets beat software clears and service clears
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_flag) begin
      nxt_flag = PWDATA_I[pti_pkg::FLAG_W-1:0];
    end
    if (can_call) begin
      nxt_flag.mf0_request_flag = 1'b0;
    end
    if (rtc_ovf) begin
      nxt_flag.rtc_request_flag = 1'b1;
    end
    if (tb_ovf) begin
      nxt_flag.tick_request_flag = 1'b1;
    end
    if (mf0_set) begin
      nxt_flag.mf0_request_flag = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      flag_ff <= pti_pkg::FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // ------------------------------------------------------------
  // wake-up
  // ------------------------------------------------------------
  // a flag already high cannot rise, which is how software masks wake
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= |(nxt_flag & ~flag_ff);
    end
  end

  assign WAKE_O = wake_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_call_gate;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    CALL_O |-> $past(ena_ff.global_irq_enable && ena_ff.mf0_irq_enable
                      && flag_ff.mf0_request_flag && !STACK_FULL_I);
  endproperty
  a_call_gate: assert property (p_call_gate) else $error("call without all enables");

  property p_call_vector;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    CALL_O |-> (VECTOR_O == 12'h024) && PUSH_PC_O ##1 !CALL_O;
  endproperty
  a_call_vector: assert property (p_call_vector) else $error("call vector or push wrong");

  property p_rtc_set;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    rtc_ovf |=> flag_ff.rtc_request_flag;
  endproperty
  a_rtc_set: assert property (p_rtc_set) else $error("rtc flag missed overflow");

  property p_tb_set;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    tb_ovf && ena_ff.tick_irq_enable |=> flag_ff.tick_request_flag && flag_ff.mf0_request_flag;
  endproperty
  a_tb_set: assert property (p_tb_set) else $error("tick overflow not flagged");

  property p_service;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    can_call && !mf0_set && !wr_flag && !wr_ena && !rtc_ovf && !tb_ovf |=>
      !ena_ff.global_irq_enable && !flag_ff.mf0_request_flag
      && flag_ff.rtc_request_flag == $past(flag_ff.rtc_request_flag)
      && flag_ff.tick_request_flag == $past(flag_ff.tick_request_flag);
  endproperty
  a_service: assert property (p_service) else $error("service cleared wrong bits");

  property p_persist;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    flag_ff.rtc_request_flag && !wr_flag |=> flag_ff.rtc_request_flag;
  endproperty
  a_persist: assert property (p_persist) else $error("request flag dropped");

  property p_wake;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    (|(flag_ff & ~$past(flag_ff))) |-> WAKE_O;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on flag rise");

  property p_return_and_unmask;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    RETURN_AND_UNMASK_I && svc_ff == pti_pkg::PTI_ISR |=> ena_ff.global_irq_enable;
  endproperty
  a_return_and_unmask: assert property (p_return_and_unmask) else $error("return did not unmask");

  property p_ret;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    RET_I && !RETURN_AND_UNMASK_I && !wr_ena && !ena_ff.global_irq_enable |=> !ena_ff.global_irq_enable;
  endproperty
  a_ret: assert property (p_ret) else $error("plain return unmasked");

  property p_ctrl_pins;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    wr_ctrl |=> (OSC_QUICK_START_O == !$past(PWDATA_I[4])) && (LVD_ENABLE_O == $past(PWDATA_I[3]));
  endproperty
  a_ctrl_pins: assert property (p_ctrl_pins) else $error("control bits not applied");

  property p_rtc_exp;
    @(posedge REF_CLK_I) disable iff (RESET_I)
    rtc_exp == 4'h8 + {1'b0, ctrl_ff.rtc_period_select};
  endproperty
  a_rtc_exp: assert property (p_rtc_exp) else $error("rtc ratio wrong");

endmodule

// ===== tb/pti_core_model.sv
// behavioural core sequencer that answers each mf0 call with a return
`timescale 1ns/10ps
module pti_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        call_i,
  input  wire logic        push_i,
  input  wire logic [11:0] vec_i,
  input  wire logic        use_return_and_unmask_i,
  input  wire logic [3:0]  lat_i,
  output logic             return_and_unmask_o,
  output logic             ret_o,
  output int               calls_o,
  output int               bad_o
);
  logic [3:0] cnt;
  logic       busy;
  // -------------------------------------------------------------
  // call intake and delayed return
  // -------------------------------------------------------------
  // entry must push only the pc, together with the call, at the mf0 vector
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      return_and_unmask_o  <= 1'b0;
      ret_o   <= 1'b0;
      calls_o <= 0;
      bad_o   <= 0;
      busy    <= 1'b0;
      cnt     <= 4'h0;
    end else begin
      return_and_unmask_o <= 1'b0;
      ret_o  <= 1'b0;
      if (call_i || push_i) begin
        calls_o <= calls_o + 1;
        if (push_i !== call_i || vec_i !== pti_pkg::MF0_VECTOR) bad_o <= bad_o + 1;
        busy <= 1'b1;
        cnt  <= lat_i;
      end else if (busy) begin
        // a slow return keeps the design parked in its service state
        if (cnt == 4'h0) begin
          busy   <= 1'b0;
          return_and_unmask_o <= use_return_and_unmask_i;
          ret_o  <= !use_return_and_unmask_i;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule

// ===== tb/tb.sv
// self-checking bench for the periodic tick interrupt block
`timescale 1ns/10ps
module tb;
  logic clk, rst, psel, pen, pwr, sense, full, sio, ext, return_and_unmask, ret, use_return_and_unmask, call, push, wake, lvd, oqs, gie;
  logic [7:0] paddr;
  logic [31:0] pwd, prd, rd, prd2, rd2;
  logic [3:0] pstrb;
  logic [11:0] vec;
  logic ready, slverr, err;
  int errors, cmp_count, cyc, calls, bad, wakes, t1, t2, c0, w0;
  localparam int TB_E = 12;
  pti_top #(.SLOW_SRC(pti_pkg::SRC_SYS_DIV4), .TB_EXP(4'hC)) dut_u (.REF_CLK_I(clk), .RESET_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PSTRB_I(pstrb),
    .PRDATA_O(prd), .PREADY_O(ready), .PSLVERR_O(slverr), .XTAL_SLOW_I(1'b0), .INTERNAL_RC_SLOW_OSC_SLOW_I(1'b0),
    .LVD_SENSE_I(sense), .STACK_FULL_I(full), .RETURN_AND_UNMASK_I(return_and_unmask), .RET_I(ret), .SIO0_REQ_I(sio),
    .EXT_PERIPH_REQ_I(ext), .CALL_O(call), .PUSH_PC_O(push), .VECTOR_O(vec), .WAKE_O(wake),
    .LVD_ENABLE_O(lvd), .OSC_QUICK_START_O(oqs), .GLOBAL_IRQ_ENABLE_O(gie));
  pti_core_model core_u (.clk_i(clk), .rst_i(rst), .call_i(call), .push_i(push), .vec_i(vec),
    .use_return_and_unmask_i(use_return_and_unmask), .lat_i(4'h5), .return_and_unmask_o(return_and_unmask), .ret_o(ret), .calls_o(calls), .bad_o(bad));
  // second copy on the crystal pin, sharing the bus; its crystal rises every 8 clocks
  pti_top #(.SLOW_SRC(pti_pkg::SRC_CRYSTAL), .TB_EXP(4'hC)) dut_xtal_u (.REF_CLK_I(clk), .RESET_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PSTRB_I(pstrb),
    .PRDATA_O(prd2), .PREADY_O(), .PSLVERR_O(), .XTAL_SLOW_I(cyc[2]), .INTERNAL_RC_SLOW_OSC_SLOW_I(1'b0),
    .LVD_SENSE_I(1'b0), .STACK_FULL_I(1'b1), .RETURN_AND_UNMASK_I(1'b0), .RET_I(1'b0), .SIO0_REQ_I(1'b0),
    .EXT_PERIPH_REQ_I(1'b0), .CALL_O(), .PUSH_PC_O(), .VECTOR_O(), .WAKE_O(),
    .LVD_ENABLE_O(), .OSC_QUICK_START_O(), .GLOBAL_IRQ_ENABLE_O());
  // -------------------------------------------------------------
  // clock, cycle counter, wake monitor and timeout
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // the ceiling covers the long time base wait with room to spare
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      results();
    end
  end
  // -------------------------------------------------------------
  // bus and compare tasks
  // -------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    rd = prd;
    rd2 = prd2;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // polls one flag bit until it reads set, noting the cycle
  // x picks the crystal-sourced copy
  task automatic poll(input int b, input bit x, output int t);
    rd = 32'h0;
    rd2 = 32'h0;
    for (int i = 0; i < 3000 && (x ? rd2[b] : rd[b]) !== 1'b1; i++) apb(1'b0, pti_pkg::FLAG_OFS, 32'h0, 4'h0);
    t = cyc;
  endtask
  task automatic wait_call(input int lim);
    c0 = calls;
    for (int i = 0; i < lim && calls == c0; i++) @(posedge clk);
    chk("calls", c0 + 1, calls);
  endtask
  task automatic results();
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    {psel, pen, pwr, sense, full, sio, ext, use_return_and_unmask} = 8'h01;
    {paddr, pwd, pstrb, errors, cmp_count, cyc, wakes} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, pti_pkg::CTRL_OFS, 32'h0, 4'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, pti_pkg::ENA_OFS, 32'h0, 4'h0);
    chk("ena reset", 32'h0, rd);
    chk("quick start out", 1'b1, oqs);
    chk("lvd enable out", 1'b0, lvd);
    // detector output bit ignores writes and follows enabled sense
    apb(1'b1, pti_pkg::CTRL_OFS, 32'h3F, 4'hF);
    apb(1'b0, pti_pkg::CTRL_OFS, 32'h0, 4'h0);
    chk("ctrl ro bit", 32'h1F, rd);
    chk("quick start off", 1'b0, oqs);
    chk("lvd enabled", 1'b1, lvd);
    sense <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b1, pti_pkg::CTRL_OFS, 32'h0, 4'h0);
    apb(1'b0, pti_pkg::CTRL_OFS, 32'h0, 4'h0);
    chk("ctrl low voltage", 32'h3F, rd);
    apb(1'b1, pti_pkg::CTRL_OFS, 32'h0, 4'hF);
    apb(1'b0, pti_pkg::CTRL_OFS, 32'h0, 4'h0);
    chk("ctrl lvd off", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0, 4'h0);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 32'h0, rd);
    // other members reach the mf0 flag directly
    sio <= 1'b1;
    @(posedge clk);
    sio <= 1'b0;
    apb(1'b0, pti_pkg::FLAG_OFS, 32'h0, 4'h0);
    chk("mf0 from sio", 1'b1, rd[2]);
    apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    apb(1'b0, pti_pkg::FLAG_OFS, 32'h0, 4'h0);
    chk("mf0 from ext", 1'b1, rd[2]);
    // a left-over mf0 flag would be called as soon as enables go up
    apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
    // rtc period for two select codes, rtc enable off so no call
    apb(1'b1, pti_pkg::ENA_OFS, 32'h9, 4'hF);
    c0 = calls;
    for (int n = 0; n < 2; n++) begin
      apb(1'b1, pti_pkg::CTRL_OFS, n, 4'hF);
      apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
      poll(0, 1'b0, t1);
      apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
      w0 = wakes;
      poll(0, 1'b0, t2);
      chk("rtc period ok", 1'b1, (t2 - t1 - (4 << (8 + n))) inside {[-10:10]});
      chk("wake on rise", 1'b1, wakes > w0);
      chk("mf0 gated", 1'b0, rd[2]);
    end
    chk("no call", c0, calls);
    apb(1'b1, pti_pkg::ENA_OFS, 32'h0, 4'hF);
    repeat (50) @(posedge clk);
    apb(1'b0, pti_pkg::FLAG_OFS, 32'h0, 4'h0);
    chk("rtc flag kept", 1'b1, rd[0]);
    // preset flags keep the next overflow from waking
    apb(1'b1, pti_pkg::CTRL_OFS, 32'h0, 4'hF);
    apb(1'b1, pti_pkg::FLAG_OFS, 32'h7, 4'hF);
    // the preset itself is a rise and wakes once; let that pulse be counted first
    repeat (2) @(posedge clk);
    w0 = wakes;
    repeat (1100) @(posedge clk);
    chk("no wake", w0, wakes);
    // stack full holds off entry; then call, service clear, return_and_unmask
    apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
    full <= 1'b1;
    apb(1'b1, pti_pkg::ENA_OFS, 32'hB, 4'hF);
    c0 = calls;
    repeat (1100) @(posedge clk);
    chk("stack full", c0, calls);
    full <= 1'b0;
    wait_call(20);
    apb(1'b0, pti_pkg::FLAG_OFS, 32'h0, 4'h0);
    chk("serviced flags", 3'h1, rd[2:0] & 3'h5);
    repeat (10) @(posedge clk);
    chk("return_and_unmask unmasks", 1'b1, gie);
    use_return_and_unmask <= 1'b0;
    apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
    wait_call(1200);
    chk("entry masks", 1'b0, gie);
    repeat (20) @(posedge clk);
    apb(1'b0, pti_pkg::ENA_OFS, 32'h0, 4'h0);
    chk("ret keeps mask", 32'hA, rd);
    chk("model faults", 0, bad);
    // time base request through mf0
    apb(1'b1, pti_pkg::ENA_OFS, 32'h0, 4'hF);
    apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
    apb(1'b1, pti_pkg::ENA_OFS, 32'hD, 4'hF);
    wait_call((4 << TB_E) + 100);
    apb(1'b0, pti_pkg::FLAG_OFS, 32'h0, 4'h0);
    chk("tick serviced", 3'h2, rd[2:1] << 1);
    // crystal source: rtc period counted in crystal rises, select still 0
    apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
    poll(0, 1'b1, t1);
    apb(1'b1, pti_pkg::FLAG_OFS, 32'h0, 4'hF);
    poll(0, 1'b1, t2);
    chk("xtal rtc period", 1'b1, (t2 - t1 - (8 << pti_pkg::RTC_EXP_BASE)) inside {[-10:10]});
    results();
  end
endmodule
